// [shared/bio_consts.vh]
`ifndef BIO_CONSTS_VH
`define BIO_CONSTS_VH

// Register indices of the two port instances; the byte address is four times the index.
`define BIO_PORT_C_BASE      16'hf260
`define BIO_PORT_D_BASE      16'hf268
`define BIO_PORT_C_SEL_LO    16'hf262
`define BIO_PORT_D_DATA      16'hf268
`define BIO_PORT_D_DIR       16'hf269
`define BIO_PORT_D_SEL_LO    16'hf26a
`define BIO_PORT_D_SEL_HI    16'hf26b

// Register positions relative to the instance base index.
`define BIO_OFS_DATA         2'd0
`define BIO_OFS_DIR          2'd1
`define BIO_OFS_SEL_LO       2'd2
`define BIO_OFS_SEL_HI       2'd3

// Reset value of every register.
`define BIO_RESET_VALUE      8'h00

// Direction bit encoding.
`define BIO_DIR_OUTPUT       1'b0
`define BIO_DIR_INPUT        1'b1

// Pin state select codes, high bit then low bit.
`define BIO_SEL_HIZ          2'b00
`define BIO_SEL_PCH_OD       2'b01
`define BIO_SEL_NCH_OD       2'b10
`define BIO_SEL_CMOS         2'b11
`define BIO_SEL_IN_PULLDOWN  2'b01
`define BIO_SEL_IN_PULLUP    2'b10

// Address layout of the 32-bit bus word.
`define BIO_ADDR_IDX_MSB     17
`define BIO_ADDR_IDX_LSB     2

`endif

// [logic/bio_sync.v]
`timescale 1ns/1ns
`default_nettype none

module bio_sync #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] stable_r;

    // The first stage is read by the second stage only.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r   <= {WIDTH{1'b0}};
            stable_r <= {WIDTH{1'b0}};
        end else begin
            meta_r   <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;

endmodule // bio_sync

`default_nettype wire

// [logic/bio_pin_drv.v]
`timescale 1ns/1ns
`default_nettype none
`include "bio_consts.vh"

module bio_pin_drv (
    input  wire dir_bit,
    input  wire sel_hi_bit,
    input  wire sel_lo_bit,
    input  wire data_bit,
    input  wire seg_select,
    input  wire seg_level,
    output reg  pin_o,
    output reg  pin_oe,
    output reg  pull_up_en,
    output reg  pull_down_en
);

    always @* begin
        pin_o        = 1'b0;
        pin_oe       = 1'b0;
        pull_up_en   = 1'b0;
        pull_down_en = 1'b0;
        if (seg_select) begin
            // The segment driver owns the pin and drives it push-pull.
            pin_o  = seg_level; // [RULE_12]
            pin_oe = 1'b1;      // [RULE_12]
        end else if (dir_bit == `BIO_DIR_OUTPUT) begin // [RULE_01]
            case ({sel_hi_bit, sel_lo_bit}) // [RULE_02]
                `BIO_SEL_PCH_OD: begin
                    pin_o  = 1'b1;
                    pin_oe = data_bit; // [RULE_05]
                end
                `BIO_SEL_NCH_OD: begin
                    pin_o  = 1'b0;
                    pin_oe = ~data_bit; // [RULE_05]
                end
                `BIO_SEL_CMOS: begin
                    pin_o  = data_bit; // [RULE_05]
                    pin_oe = 1'b1;
                end
                default: begin
                    pin_o  = 1'b0;
                    pin_oe = 1'b0;
                end
            endcase
        end else begin
            case ({sel_hi_bit, sel_lo_bit}) // [RULE_03]
                `BIO_SEL_IN_PULLDOWN: pull_down_en = 1'b1;
                `BIO_SEL_IN_PULLUP:   pull_up_en   = 1'b1;
                default: begin
                    pull_up_en   = 1'b0;
                    pull_down_en = 1'b0;
                end
            endcase
        end
    end

endmodule // bio_pin_drv

`default_nettype wire

// [logic/bio_port.v]
// Function
// [RULE_01] Direction bit 0 output, 1 input.
// [RULE_02] Output select: hi-Z, P-open, N-open, CMOS.
// [RULE_03] Input select: hi-Z, pull-down, pull-up, hi-Z.
// [RULE_04] Reset clears all registers, hi-Z outputs.
// [RULE_05] Output pin follows data bit.
// [RULE_06] Input pins read back sampled pin level.
// [RULE_07] Data writes stored, output pins read back.
// [RULE_08] Port D data, direction, select registers decoded.
// [RULE_09] Select pair accessible as bytes or word.
// [RULE_10] Select bit n controls pin n.
// [RULE_11] Each pin configured independently.
// [RULE_12] Segment select hands pin to LCD driver.
// [RULE_13] Writes act at clock edge; reads combinational.
`timescale 1ns/1ns
`default_nettype none
`include "bio_consts.vh"

module bio_port #(
    parameter [15:0] BASE_INDEX = `BIO_PORT_D_BASE,
    parameter        NUM_PINS   = 8
) (
    input  wire                pclk,
    input  wire                presetn,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [31:0]         paddr,
    input  wire [31:0]         pwdata,
    input  wire [3:0]          pstrb,
    output reg  [31:0]         prdata,
    output wire                pready,
    output reg                 pslverr,
    input  wire [NUM_PINS-1:0] pin_i,
    output wire [NUM_PINS-1:0] pin_o,
    output wire [NUM_PINS-1:0] pin_oe,
    output wire [NUM_PINS-1:0] pull_up_en,
    output wire [NUM_PINS-1:0] pull_down_en,
    input  wire [NUM_PINS-1:0] lcd_segment_select,
    input  wire [NUM_PINS-1:0] lcd_segment_level
);

    // Register storage.
    reg  [NUM_PINS-1:0] pin_value_r;
    reg  [NUM_PINS-1:0] pin_direction_r;
    reg  [NUM_PINS-1:0] sel_low_r;
    reg  [NUM_PINS-1:0] sel_high_r;

    // Next values.
    reg  [NUM_PINS-1:0] pin_value_nxt;
    reg  [NUM_PINS-1:0] pin_direction_nxt;
    reg  [NUM_PINS-1:0] sel_low_nxt;
    reg  [NUM_PINS-1:0] sel_high_nxt;

    // Bus decode.
    wire [15:0]         acc_index;
    wire                addr_high_zero;
    wire                addr_aligned;
    wire                hit_data;
    wire                hit_dir;
    wire                hit_sel_lo;
    wire                hit_sel_hi;
    wire                hit_any;
    wire                access_phase;
    wire                wr_en;
    wire                rd_en;

    // Pin sampling.
    wire [NUM_PINS-1:0] pin_level_sync;
    wire [NUM_PINS-1:0] data_readback;

    // True when the bus index equals the instance base plus an offset.
    function match_index;
        input [15:0] index;
        input [15:0] base;
        input [1:0]  offset;
        begin
            match_index = (index == (base + {14'h0000, offset}));
        end
    endfunction

    // Merges one byte lane of write data into a register value.
    function [7:0] lane_merge;
        input [7:0] current;
        input [7:0] wdata;
        input       strobe;
        begin
            if (strobe) begin
                lane_merge = wdata;
            end else begin
                lane_merge = current;
            end
        end
    endfunction

    // Zero extends one byte to the bus width.
    function [31:0] byte_to_word;
        input [7:0] value;
        begin
            byte_to_word = {24'h000000, value};
        end
    endfunction

    // Address decode: every register sits at four times its index.
    assign acc_index      = paddr[`BIO_ADDR_IDX_MSB:`BIO_ADDR_IDX_LSB];
    assign addr_high_zero = (paddr[31:`BIO_ADDR_IDX_MSB+1] == 14'h0000);
    assign addr_aligned   = (paddr[1:0] == 2'b00);

    assign hit_data   = addr_high_zero & addr_aligned &
                        match_index(acc_index, BASE_INDEX, `BIO_OFS_DATA);   // [RULE_08]
    assign hit_dir    = addr_high_zero & addr_aligned &
                        match_index(acc_index, BASE_INDEX, `BIO_OFS_DIR);    // [RULE_08]
    assign hit_sel_lo = addr_high_zero & addr_aligned &
                        match_index(acc_index, BASE_INDEX, `BIO_OFS_SEL_LO); // [RULE_08]
    assign hit_sel_hi = addr_high_zero & addr_aligned &
                        match_index(acc_index, BASE_INDEX, `BIO_OFS_SEL_HI); // [RULE_08]
    assign hit_any    = hit_data | hit_dir | hit_sel_lo | hit_sel_hi;

    // The slave never inserts wait states.
    assign pready       = 1'b1;
    assign access_phase = psel & penable;
    assign wr_en        = access_phase & pwrite & hit_any;
    assign rd_en        = access_phase & ~pwrite & hit_any;

    // Pin levels pass two flops before software or logic sees them.
    bio_sync #(
        .WIDTH    (NUM_PINS)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_i),
        .sync_out (pin_level_sync)
    );

    // Next-value logic for the data register.
    always @* begin
        pin_value_nxt = pin_value_r;
        if (wr_en && hit_data) begin
            // The value is stored even for input pins and drives once they turn to output.
            pin_value_nxt = lane_merge(pin_value_r, pwdata[7:0], pstrb[0]); // [RULE_07]
        end
    end

    // Next-value logic for the direction register.
    always @* begin
        pin_direction_nxt = pin_direction_r;
        if (wr_en && hit_dir) begin
            pin_direction_nxt = lane_merge(pin_direction_r, pwdata[7:0], pstrb[0]); // [RULE_11]
        end
    end

    // Next-value logic for the low select register.
    always @* begin
        sel_low_nxt = sel_low_r;
        if (wr_en && hit_sel_lo) begin
            sel_low_nxt = lane_merge(sel_low_r, pwdata[7:0], pstrb[0]); // [RULE_09]
        end
    end

    // Next-value logic for the high select register, written alone or as the word's upper byte.
    always @* begin
        sel_high_nxt = sel_high_r;
        if (wr_en && hit_sel_hi) begin
            sel_high_nxt = lane_merge(sel_high_r, pwdata[7:0], pstrb[0]);
        end else if (wr_en && hit_sel_lo) begin
            sel_high_nxt = lane_merge(sel_high_r, pwdata[15:8], pstrb[1]); // [RULE_09]
        end
    end

    // Register update on the edge that completes the write.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_value_r     <= `BIO_RESET_VALUE; // [RULE_04]
            pin_direction_r <= `BIO_RESET_VALUE; // [RULE_04]
            sel_low_r       <= `BIO_RESET_VALUE; // [RULE_04]
            sel_high_r      <= `BIO_RESET_VALUE; // [RULE_04]
        end else begin
            pin_value_r     <= pin_value_nxt;     // [RULE_13]
            pin_direction_r <= pin_direction_nxt; // [RULE_13]
            sel_low_r       <= sel_low_nxt;       // [RULE_13]
            sel_high_r      <= sel_high_nxt;      // [RULE_13]
        end
    end

    // Input pins return the sampled level, output pins the stored value.
    assign data_readback = (pin_direction_r & pin_level_sync) |
                           (~pin_direction_r & pin_value_r); // [RULE_06]

    // Read data is combinational so it is valid in the access phase.
    always @* begin
        prdata = 32'h00000000;
        if (rd_en) begin
            if (hit_data) begin
                prdata = byte_to_word(data_readback); // [RULE_06]
            end else if (hit_dir) begin
                prdata = byte_to_word(pin_direction_r); // [RULE_13]
            end else if (hit_sel_lo) begin
                // A word read at the low select index returns both select bytes.
                prdata = {16'h0000, sel_high_r, sel_low_r}; // [RULE_09]
            end else if (hit_sel_hi) begin
                prdata = byte_to_word(sel_high_r);
            end else begin
                prdata = 32'h00000000;
            end
        end
    end

    // Unmapped or misaligned addresses answer with an error and change nothing.
    always @* begin
        pslverr = 1'b0;
        if (access_phase && !hit_any) begin
            pslverr = 1'b1;
        end
    end

    // One drive decoder per pin, each seeing only its own bits.
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
            bio_pin_drv u_drv (
                .dir_bit      (pin_direction_r[g]),    // [RULE_11]
                .sel_hi_bit   (sel_high_r[g]),         // [RULE_10]
                .sel_lo_bit   (sel_low_r[g]),          // [RULE_10]
                .data_bit     (pin_value_r[g]),
                .seg_select   (lcd_segment_select[g]), // [RULE_12]
                .seg_level    (lcd_segment_level[g]),
                .pin_o        (pin_o[g]),
                .pin_oe       (pin_oe[g]),
                .pull_up_en   (pull_up_en[g]),
                .pull_down_en (pull_down_en[g])
            );
        end
    endgenerate

endmodule // bio_port

`default_nettype wire

// [tb/bio_port_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module bio_port_sva #(
    parameter [15:0] BASE_INDEX = 16'hf268,
    parameter        NUM_PINS   = 8
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [31:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [3:0]          pstrb,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [NUM_PINS-1:0] pin_i,
    input wire logic [NUM_PINS-1:0] pin_o,
    input wire logic [NUM_PINS-1:0] pin_oe,
    input wire logic [NUM_PINS-1:0] pull_up_en,
    input wire logic [NUM_PINS-1:0] pull_down_en,
    input wire logic [NUM_PINS-1:0] lcd_segment_select,
    input wire logic [NUM_PINS-1:0] lcd_segment_level
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire        acc = psel && penable;
    wire        ok  = (paddr[1:0] == 2'b00) && (paddr[31:18] == 14'h0);
    wire [15:0] rel = paddr[17:2] - BASE_INDEX;
    wire        hit = ok && (rel < 16'd4);
    wire        wr0 = acc && pwrite && pstrb[0] && hit;
    wire [NUM_PINS-1:0] ls = lcd_segment_select;
    property p_misalign; acc && !ok |-> pslverr && (prdata == 32'h0); endproperty
    a_misalign: assert property (p_misalign) else $error("bad address accepted");
    property p_mapped; acc && hit |-> !pslverr && pready; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_word;
        acc && !pwrite && hit |-> (rel == 16'd2) ? (prdata[31:16] == 16'h0) : (prdata[31:8] == 24'h0);
    endproperty
    a_word: assert property (p_word) else $error("unused read lanes not zero");
    property p_dir;
        logic [NUM_PINS-1:0] v;
        (wr0 && rel == 16'd1, v = pwdata[NUM_PINS-1:0]) |=> (pin_oe & v & ~ls) == '0;
    endproperty
    a_dir: assert property (p_dir) else $error("input pin still driven");
    property p_data;
        logic [NUM_PINS-1:0] v;
        (wr0 && rel == 16'd0, v = pwdata[NUM_PINS-1:0]) |=> ((pin_o ^ v) & pin_oe & ~ls) == '0;
    endproperty
    a_data: assert property (p_data) else $error("driven level differs from data");
    property p_lcd; (pin_oe & ls) == ls && ((pin_o ^ lcd_segment_level) & ls) == '0; endproperty
    a_lcd: assert property (p_lcd) else $error("segment level not driven");
    property p_pull;
        ((pull_up_en & pull_down_en) | ((pull_up_en | pull_down_en) & pin_oe & ~ls)) == '0;
    endproperty
    a_pull: assert property (p_pull) else $error("pull enabled on driven pin");
    property p_reset;
        $rose(presetn) |-> pin_oe == ls && ((pull_up_en | pull_down_en) & ~ls) == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("pins not idle after reset");
    c_data: cover property (wr0 && rel == 16'd0);
    c_err: cover property (acc && !ok);
    c_up: cover property (|pull_up_en);
    c_down: cover property (|pull_down_en);
endmodule // bio_port_sva
bind bio_port bio_port_sva #(.BASE_INDEX(BASE_INDEX), .NUM_PINS(NUM_PINS)) bio_port_sva_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .lcd_segment_select(lcd_segment_select), .lcd_segment_level(lcd_segment_level));
`default_nettype wire

// [tb/bio_board.sv]
`timescale 1ns/1ns
`default_nettype none
module bio_board (
    input  wire logic       pclk,
    input  wire logic [7:0] pin_o,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pull_up_en,
    input  wire logic [7:0] pull_down_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output wire logic [7:0] pin_lvl
);
    // A pin nobody drives or pulls flips every cycle so that a stale level is never read.
    logic [7:0] float_r = 8'h5a;
    always @(posedge pclk) begin
        float_r <= ~float_r;
    end
    assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ((ext_en & ext_val)
                     | (~ext_en & (pull_up_en | (~pull_down_en & float_r)))));
endmodule // bio_board
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "bio_consts.vh"
module tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, rd, ep;
    logic [3:0]  pstrb = 4'h0;
    logic [7:0]  ls = 8'h0, ll = 8'h0, ee = 8'h0, ev = 8'h0, d, dr, lo, hi, m, lv;
    logic        er, sel_c = 1'b0;
    wire  [31:0] prdata, prdata_c;
    wire         pready, pslverr, pready_c, pslverr_c;
    wire  [7:0]  pin_i, pin_o, pin_oe, pu, pd, pin_o_c, pin_oe_c, pu_c, pd_c;
    integer      num_errors = 0, samples_checked = 0, cyc = 0, it;

    bio_port #(.BASE_INDEX(`BIO_PORT_D_BASE), .NUM_PINS(8)) bio_port_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pull_up_en(pu),
        .pull_down_en(pd), .lcd_segment_select(ls), .lcd_segment_level(ll));
    // A port C unit on the same bus checks the other base and that writes stay apart.
    bio_port #(.BASE_INDEX(`BIO_PORT_C_BASE), .NUM_PINS(8)) bio_port_c_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_c), .pready(pready_c),
        .pslverr(pslverr_c), .pin_i(pin_i), .pin_o(pin_o_c), .pin_oe(pin_oe_c),
        .pull_up_en(pu_c), .pull_down_en(pd_c), .lcd_segment_select(ls), .lcd_segment_level(ll));
    bio_board bio_board_i (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .pull_up_en(pu),
        .pull_down_en(pd), .ext_en(ee), .ext_val(ev), .pin_lvl(pin_i));

    always #5 pclk = ~pclk;

    task tally_and_finish;
        begin
            $display("checks %0d errors %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            tally_and_finish;
        end
    end

    task chk(input [31:0] seen, input [31:0] exp, input string nm);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // One transfer, entered just after a rising edge; one idle cycle follows it.
    task apb(input [2:0] ofs, input [1:0] bl, input wr, input [31:0] wd, input [3:0] st);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= wr;
            paddr <= {14'h0, (sel_c ? `BIO_PORT_C_BASE : `BIO_PORT_D_BASE) + {13'h0, ofs}, bl};
            pwdata <= wd;
            pstrb <= st;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while ((sel_c ? pready_c : pready) !== 1'b1) @(posedge pclk);
            rd = sel_c ? prdata_c : prdata;
            er = sel_c ? pslverr_c : pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    function [31:0] exp_pins();
        logic [7:0] oe;
        begin
            oe = ls | (~dr & ((~hi & lo & d) | (hi & ~lo & ~d) | (hi & lo)));
            exp_pins = {dr & lo & ~hi & ~ls, dr & hi & ~lo & ~ls, oe, ((ls & ll) | (~ls & d)) & oe};
        end
    endfunction

    initial begin
        void'($urandom(89));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (it = 0; it < 4; it++) begin
            apb(it[2:0], 2'b00, 1'b0, 32'h0, 4'h0);
            chk(rd, 32'h0, "reset_reg");
        end
        for (it = 0; it < 40; it++) begin
            ls <= 8'($urandom & $urandom & $urandom);
            ll <= 8'($urandom);
            ee <= 8'($urandom);
            ev <= 8'($urandom);
            {dr, lo, hi, d} = $urandom;
            if (it < 2) begin
                dr = {8{it[0]}};
                lo = 8'h5a;
                hi = 8'h3c;
            end
            apb(3'd1, 2'b00, 1'b1, {24'($urandom), dr}, 4'h1);
            if (it[0]) begin
                apb(3'd2, 2'b00, 1'b1, {16'($urandom), hi, lo}, 4'h3);
            end else begin
                apb(3'd2, 2'b00, 1'b1, {24'h0, lo}, 4'h1);
                apb(3'd3, 2'b00, 1'b1, {24'h0, hi}, 4'h1);
            end
            apb(3'd0, 2'b00, 1'b1, {24'($urandom), d}, 4'h1);
            apb(3'd0, 2'b00, 1'b1, {24'h0, ~d}, 4'h0);
            apb(3'd0, 2'b01, 1'b1, {24'h0, ~d}, 4'h1);
            chk({31'h0, er}, 32'h1, "misaligned_err");
            ep = exp_pins();
            chk({24'h0, pin_oe}, {24'h0, ep[15:8]}, "pin_oe");
            chk({24'h0, pin_o & pin_oe}, {24'h0, ep[7:0]}, "pin_o");
            chk({16'h0, pd & ~ls, pu & ~ls}, {16'h0, ep[31:16]}, "pulls");
            apb(3'd1, 2'b00, 1'b0, 32'h0, 4'h0);
            chk(rd, {24'h0, dr}, "direction");
            apb(3'd2, 2'b00, 1'b0, 32'h0, 4'h0);
            chk(rd, {16'h0, hi, lo}, "select_word");
            apb(3'd3, 2'b00, 1'b0, 32'h0, 4'h0);
            chk(rd, {24'h0, hi}, "select_high");
            apb(3'd4, 2'b00, 1'b0, 32'h0, 4'h0);
            chk({er, rd[30:0]}, 32'h80000000, "unmapped");
            lv = (ls & ll) | (~ls & ((ee & ev) | (~ee & hi & ~lo)));
            m = ~dr | ls | ee | (lo ^ hi);
            apb(3'd0, 2'b00, 1'b0, 32'h0, 4'h0);
            chk(rd & {24'h0, m}, {24'h0, ((~dr & d) | (dr & lv)) & m}, "data");
        end
        // Port C: only its select word is written, so data and direction keep reset values.
        sel_c = 1'b1;
        {d, dr, lo, hi} = {16'h0, 16'($urandom)};
        apb(3'd2, 2'b00, 1'b1, {16'h0, hi, lo}, 4'h3);
        apb(3'd2, 2'b00, 1'b0, 32'h0, 4'h0);
        chk(rd, {16'h0, hi, lo}, "c_select_word");
        chk({31'h0, er}, 32'h0, "c_select_err");
        apb(3'd3, 2'b00, 1'b0, 32'h0, 4'h0);
        chk(rd, {24'h0, hi}, "c_select_high");
        apb(3'd0, 2'b00, 1'b0, 32'h0, 4'h0);
        chk(rd, 32'h0, "c_data");
        ep = exp_pins();
        chk({24'h0, pin_oe_c}, {24'h0, ep[15:8]}, "c_pin_oe");
        chk({24'h0, pin_o_c & pin_oe_c}, {24'h0, ep[7:0]}, "c_pin_o");
        chk({16'h0, pd_c, pu_c}, {16'h0, ep[31:16]}, "c_pulls");
        tally_and_finish;
    end
endmodule // tb
`default_nettype wire
